// ---- rtl/mms_map.vh ----
// Purpose: constants for the monitor measurement sequencer
// Assumes: 25 MHz ref_clk; 8-bit register port from the serial front end
// Notes: Functional notes below, then offsets, fields and timings
//
// Functional notes
// - Reset gives round-robin with monitoring off; config one bit 0 starts.
// - Round-robin order is supply, on-chip temperature, external temperature.
// - After external conversion the cycle restarts while monitoring is on.
// - Config two bit 4 leaves round-robin and selects single-channel mode.
// - Single-channel mode converts only the selected channel, back to back.
// - Select 00 converts supply; select 01 converts on-chip temperature.
// - Temperature results average 16 conversions while averaging is enabled.
// - Config two bit 5 set disables averaging; averaging is on after reset.
// - One conversion takes 712 us internal and 1.51 ms external.
// - Each 10-bit temperature result lands in a pair of 8-bit registers.
// - A serial transfer aborts conversion and resets the ADC; restart after.
// - Temperature is twos complement, 0.25 degree step, -128 to +127.
// - Supply result upper 8 bits at 0x06, lower 2 bits at 0x03.
// - Supply code is 7 V full scale on a 2.28 V reference, 3FF.
// - Internal reference is selected while any channel is converted.
// - Reference amplifier is powered while monitoring is enabled.
// - Temperature results compared with own limits; unmasked hits flag 0x00.
// - Supply result compared with limits; unmasked hits flag status two.
// - Interrupt output asserts on any flag, with selectable polarity.
// - High check is greater than; low check is less than or equal.
// - Limits are compared against the upper 8 bits of the result.
// - Low-bits read locks its upper-bits registers; upper read unlocks all.
`ifndef MMS_MAP_VH
`define MMS_MAP_VH

// Register offsets
`define MMS_A_TFLAG 8'h00
`define MMS_A_LOW_A 8'h03
`define MMS_A_LOW_B 8'h04
`define MMS_A_VDD_MSB 8'h06
`define MMS_A_INT_MSB 8'h07
`define MMS_A_EXT_MSB 8'h08
`define MMS_A_VFLAG 8'h10
`define MMS_A_CFG1 8'h18
`define MMS_A_CFG2 8'h19

// Config fields
`define MMS_B_MON_EN 0
`define MMS_B_SINGLE 4
`define MMS_B_AVG_DIS 5
`define MMS_CFG1_RST 8'h00
`define MMS_CFG2_RST 8'h00

// Channel codes
`define MMS_CH_VDD 2'h0
`define MMS_CH_INT 2'h1
`define MMS_CH_EXT 2'h2
`define MMS_CH_RSV 2'h3

// Averaging
`define MMS_AVG_LAST 4'hF

// Timing
`define MMS_CLK_NS 40
`define MMS_T_INT_US 712
`define MMS_T_EXT_US 1510
`define MMS_T_VDD_US 712

`endif

// ---- rtl/mms_sequencer.v ----
// Purpose: measurement sequencer for supply and temperature monitoring
// Assumes: ADC data valid at end of each timed conversion window
// Notes: register port is fed by an external serial protocol engine
`timescale 1ns/1ps
`include "mms_map.vh"

module mms_sequencer #(
    parameter INT_CYC = `MMS_T_INT_US * 1000 / `MMS_CLK_NS,
    parameter EXT_CYC = `MMS_T_EXT_US * 1000 / `MMS_CLK_NS,
    parameter VDD_CYC = `MMS_T_VDD_US * 1000 / `MMS_CLK_NS,
    parameter CNT_W = 16
) (
    // Clock and reset
    input wire ref_clk,
    input wire resetn,
    // Register port from the serial front end
    input wire xfer_active,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // ADC and reference control
    output reg adc_start,
    output reg [1:0] adc_chan,
    output wire adc_reset,
    output wire adc_ref_int,
    output wire ref_amp_on,
    input wire [9:0] adc_data,
    // Limits, masks and interrupt
    input wire [7:0] int_hi_lim,
    input wire [7:0] int_lo_lim,
    input wire [7:0] ext_hi_lim,
    input wire [7:0] ext_lo_lim,
    input wire [7:0] vdd_hi_lim,
    input wire [7:0] vdd_lo_lim,
    input wire [5:0] limit_mask,
    input wire int_active_high,
    output reg int_out
);

    localparam ST_IDLE = 1'b0;
    localparam ST_CONV = 1'b1;

    // Greater-than check on upper result bits
    function mms_over;
        input [7:0] r;
        input [7:0] l;
        input sgn;
        begin
            if (sgn) begin
                mms_over = $signed(r) > $signed(l);
            end else begin
                mms_over = r > l;
            end
        end
    endfunction

    // Less-or-equal check on upper result bits
    function mms_under;
        input [7:0] r;
        input [7:0] l;
        input sgn;
        begin
            if (sgn) begin
                mms_under = $signed(r) <= $signed(l);
            end else begin
                mms_under = r <= l;
            end
        end
    endfunction

    // Conversion window per channel
    function [CNT_W-1:0] mms_len;
        input [1:0] ch;
        begin
            case (ch)
                `MMS_CH_INT: mms_len = INT_CYC[CNT_W-1:0];
                `MMS_CH_EXT: mms_len = EXT_CYC[CNT_W-1:0];
                default: mms_len = VDD_CYC[CNT_W-1:0];
            endcase
        end
    endfunction

    reg [7:0] cfg1_q;
    reg [7:0] cfg2_q;
    reg state_q;
    reg [1:0] rr_ch_q;
    reg [CNT_W-1:0] cnt_q;
    reg [3:0] nsamp_q;
    reg [13:0] acc_q;
    reg [7:0] vdd_msb_q;
    reg [7:0] int_msb_q;
    reg [7:0] ext_msb_q;
    reg [1:0] vdd_lsb_q;
    reg [1:0] int_lsb_q;
    reg [1:0] ext_lsb_q;
    reg lock_a_q;
    reg lock_b_q;
    reg [3:0] tflag_q;
    reg [1:0] vflag_q;

    wire mon_en = cfg1_q[`MMS_B_MON_EN];
    wire single = cfg2_q[`MMS_B_SINGLE];
    wire avg_dis = cfg2_q[`MMS_B_AVG_DIS];
    // A transfer in flight holds the sequencer off
    wire running = mon_en & ~xfer_active;
    wire [1:0] next_ch = single ? cfg2_q[1:0] : rr_ch_q;
    wire is_temp = (adc_chan != `MMS_CH_VDD);
    wire [13:0] acc_sum = acc_q + {{4{adc_data[9]}}, adc_data};
    wire last = (nsamp_q == `MMS_AVG_LAST) | avg_dis | ~is_temp;
    // Averaged result is sum over 16, else the single sample
    wire [9:0] result = (avg_dis | ~is_temp) ? adc_data : acc_sum[13:4];
    wire done = (state_q == ST_CONV) & (cnt_q == {CNT_W{1'b0}}) & running;
    wire commit = done & last;
    wire [7:0] res8 = result[9:2];

    // Per-channel limit hits, masked, gated by commit
    reg [3:0] tset;
    reg [1:0] vset;
    always @* begin
        tset = 4'h0;
        vset = 2'h0;
        if (commit) begin
            case (adc_chan)
                `MMS_CH_INT: begin
                    tset[0] = mms_over(res8, int_hi_lim, 1'b1);
                    tset[1] = mms_under(res8, int_lo_lim, 1'b1);
                end
                `MMS_CH_EXT: begin
                    tset[2] = mms_over(res8, ext_hi_lim, 1'b1);
                    tset[3] = mms_under(res8, ext_lo_lim, 1'b1);
                end
                default: begin
                    vset[0] = mms_over(res8, vdd_hi_lim, 1'b0);
                    vset[1] = mms_under(res8, vdd_lo_lim, 1'b0);
                end
            endcase
        end
        tset = tset & ~limit_mask[3:0];
        vset = vset & ~limit_mask[5:4];
    end

    // Reference stays internal for every conversion; amp follows enable
    assign adc_ref_int = (state_q == ST_CONV);
    assign ref_amp_on = mon_en;
    assign adc_reset = ~running;

    // Configuration writes
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cfg1_q <= `MMS_CFG1_RST;
            cfg2_q <= `MMS_CFG2_RST;
        end else if (reg_wr) begin
            if (reg_addr == `MMS_A_CFG1) begin
                cfg1_q <= {7'h00, reg_wdata[`MMS_B_MON_EN]};
            end
            if (reg_addr == `MMS_A_CFG2) begin
                cfg2_q <= {2'h0, reg_wdata[5:4], 2'h0, reg_wdata[1:0]};
            end
        end
    end

    // Conversion sequencer; an abort drops partial sums
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            rr_ch_q <= `MMS_CH_VDD;
            cnt_q <= {CNT_W{1'b0}};
            nsamp_q <= 4'h0;
            acc_q <= 14'h0000;
            adc_start <= 1'b0;
            adc_chan <= `MMS_CH_VDD;
        end else if (!running) begin
            state_q <= ST_IDLE;
            nsamp_q <= 4'h0;
            acc_q <= 14'h0000;
            adc_start <= 1'b0;
            if (!mon_en) begin
                rr_ch_q <= `MMS_CH_VDD;
            end
        end else begin
            adc_start <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    // Reserved select code simply idles
                    if (next_ch != `MMS_CH_RSV) begin
                        adc_chan <= next_ch;
                        cnt_q <= mms_len(next_ch);
                        adc_start <= 1'b1;
                        state_q <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (cnt_q != {CNT_W{1'b0}}) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else if (last) begin
                        nsamp_q <= 4'h0;
                        acc_q <= 14'h0000;
                        state_q <= ST_IDLE;
                        case (adc_chan)
                            `MMS_CH_VDD: rr_ch_q <= `MMS_CH_INT;
                            `MMS_CH_INT: rr_ch_q <= `MMS_CH_EXT;
                            default: rr_ch_q <= `MMS_CH_VDD;
                        endcase
                    end else begin
                        nsamp_q <= nsamp_q + 1'b1;
                        acc_q <= acc_sum;
                        cnt_q <= mms_len(adc_chan);
                        adc_start <= 1'b1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Result registers; upper bytes hold while locked
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            vdd_msb_q <= 8'h00;
            int_msb_q <= 8'h00;
            ext_msb_q <= 8'h00;
            vdd_lsb_q <= 2'h0;
            int_lsb_q <= 2'h0;
            ext_lsb_q <= 2'h0;
        end else if (commit) begin
            case (adc_chan)
                `MMS_CH_INT: begin
                    int_lsb_q <= result[1:0];
                    if (!lock_a_q) begin
                        int_msb_q <= result[9:2];
                    end
                end
                `MMS_CH_EXT: begin
                    ext_lsb_q <= result[1:0];
                    if (!lock_b_q) begin
                        ext_msb_q <= result[9:2];
                    end
                end
                default: begin
                    // Supply code is the raw scaled ADC word
                    vdd_lsb_q <= result[1:0];
                    if (!lock_a_q) begin
                        vdd_msb_q <= result[9:2];
                    end
                end
            endcase
        end
    end

    // Read-side locking of the upper-bits registers
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            lock_a_q <= 1'b0;
            lock_b_q <= 1'b0;
        end else if (reg_rd) begin
            case (reg_addr)
                `MMS_A_LOW_A: lock_a_q <= 1'b1;
                `MMS_A_LOW_B: lock_b_q <= 1'b1;
                `MMS_A_VDD_MSB, `MMS_A_INT_MSB, `MMS_A_EXT_MSB: begin
                    lock_a_q <= 1'b0;
                    lock_b_q <= 1'b0;
                end
                default: lock_a_q <= lock_a_q;
            endcase
        end
    end

    // Sticky flags clear on read; a new hit in that cycle wins
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tflag_q <= 4'h0;
            vflag_q <= 2'h0;
        end else begin
            if (reg_rd && reg_addr == `MMS_A_TFLAG) begin
                tflag_q <= tset;
            end else begin
                tflag_q <= tflag_q | tset;
            end
            if (reg_rd && reg_addr == `MMS_A_VFLAG) begin
                vflag_q <= vset;
            end else begin
                vflag_q <= vflag_q | vset;
            end
        end
    end

    // Interrupt pin follows any flag with chosen polarity
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            int_out <= 1'b0;
        end else begin
            int_out <= ~((|tflag_q) | (|vflag_q)) ^ int_active_high;
        end
    end

    // Read data, registered one cycle after the strobe
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `MMS_A_TFLAG: reg_rdata <= {4'h0, tflag_q};
                `MMS_A_LOW_A: reg_rdata <= {4'h0, int_lsb_q, vdd_lsb_q};
                `MMS_A_LOW_B: reg_rdata <= {6'h00, ext_lsb_q};
                `MMS_A_VDD_MSB: reg_rdata <= vdd_msb_q;
                `MMS_A_INT_MSB: reg_rdata <= int_msb_q;
                `MMS_A_EXT_MSB: reg_rdata <= ext_msb_q;
                `MMS_A_VFLAG: reg_rdata <= {6'h00, vflag_q};
                `MMS_A_CFG1: reg_rdata <= cfg1_q;
                `MMS_A_CFG2: reg_rdata <= cfg2_q;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule

// ---- test/mms_props.sv ----
// Purpose: port assertions for the measurement sequencer
// Assumes: one clock domain, resetn async active low
// Notes: mode bits are unseen here, so channel order is left to the bench
`timescale 1ns/1ps
module mms_props (
    // Clock and reset
    input wire ref_clk,
    input wire resetn,
    // Register port
    input wire xfer_active,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // ADC control
    input wire adc_start,
    input wire [1:0] adc_chan,
    input wire adc_reset,
    input wire adc_ref_int,
    input wire ref_amp_on
);
    default clocking dcb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // ADC held in reset when off or during a transfer
    a_adc_reset_level: assert property (
        adc_reset == !(ref_amp_on && !xfer_active)) else $error("adc reset");
    a_no_start_off: assert property (
        !$past(ref_amp_on) |-> !adc_start) else $error("start while off");
    a_ref_in_conv: assert property (
        adc_start |-> adc_ref_int) else $error("no internal ref");
    a_start_single: assert property (
        adc_start |=> !adc_start) else $error("start too long");
    // Transfers stop conversion and it resumes shortly after
    a_abort_quiet: assert property (
        xfer_active && $past(xfer_active) |-> !adc_start)
        else $error("start in transfer");
    a_abort_restart: assert property (
        $fell(xfer_active) && ref_amp_on |-> ##[1:3] adc_start)
        else $error("no restart");
    a_chan_legal: assert property (
        adc_start |-> adc_chan != 2'h3) else $error("reserved channel");
    a_chan_steady: assert property (
        adc_ref_int && !adc_start |-> $stable(adc_chan))
        else $error("channel moved");
    // Read data holds between reads so the host can fetch it later
    a_rdata_hold: assert property (
        !$past(reg_rd) |-> $stable(reg_rdata)) else $error("rdata moved");
    c_ext: cover property (adc_start && adc_chan == 2'h2);
    c_int: cover property (adc_start && adc_chan == 2'h1);
    c_restart: cover property ($fell(xfer_active) && ref_amp_on);
endmodule

// ---- test/mms_adc_model.sv ----
// Purpose: ADC stand-in for the sequencer bench
// Assumes: one fixed code per channel from the bench
// Notes: output wanders when idle, so stale data never matches
`timescale 1ns/1ps
module mms_adc_model (
    // Clock
    input wire ref_clk,
    // Sequencer control
    input wire adc_reset,
    input wire adc_ref_int,
    input wire [1:0] adc_chan,
    // Codes per channel
    input wire [9:0] vdd_code,
    input wire [9:0] int_code,
    input wire [9:0] ext_code,
    // Result word
    output reg [9:0] adc_data
);
    // Code only while converting on the internal reference
    initial adc_data = 10'h155;
    always @(posedge ref_clk) begin
        if (adc_reset || !adc_ref_int)
            adc_data <= ~adc_data;
        else if (adc_chan == 2'h0)
            adc_data <= vdd_code;
        else if (adc_chan == 2'h1)
            adc_data <= int_code;
        else
            adc_data <= ext_code;
    end
endmodule

// ---- test/tb_top.sv ----
// Purpose: self-checking bench for the measurement sequencer
// Assumes: conversion windows cut to four cycles
// Notes: random codes and limits from a fixed seed, corners by hand
`timescale 1ns/1ps
module tb_top;
    // Stimulus, expectations and outputs
    reg ref_clk, resetn, xfer_active, reg_wr, reg_rd, int_active_high;
    reg [7:0] reg_addr, reg_wdata, got, fl0, fl1;
    reg [7:0] int_hi_lim, int_lo_lim, ext_hi_lim, ext_lo_lim;
    reg [7:0] vdd_hi_lim, vdd_lo_lim;
    reg [5:0] limit_mask;
    reg [9:0] vv, tv, ev;
    reg [1:0] ch;
    wire [7:0] reg_rdata;
    wire [9:0] adc_data;
    wire [1:0] adc_chan;
    wire adc_start, adc_reset, adc_ref_int, ref_amp_on, int_out;
    integer miscompares, n_tests, seed, starts, i, k, n, cnt;
    // Short windows keep a full round to 18 cycles with averaging off, 168 with averaging on
    mms_sequencer #(.INT_CYC(4), .EXT_CYC(4), .VDD_CYC(4)) u_dut (
        .ref_clk, .resetn, .xfer_active, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rd, .reg_rdata, .adc_start, .adc_chan, .adc_reset,
        .adc_ref_int, .ref_amp_on, .adc_data, .int_hi_lim, .int_lo_lim,
        .ext_hi_lim, .ext_lo_lim, .vdd_hi_lim, .vdd_lo_lim, .limit_mask,
        .int_active_high, .int_out);
    mms_adc_model u_adc (.ref_clk, .adc_reset, .adc_ref_int, .adc_chan,
        .vdd_code(vv), .int_code(tv), .ext_code(ev), .adc_data);
    // Clock and start counter
    initial forever #20 ref_clk = ~ref_clk;
    // Single owner of the count, cleared while reset is held
    always @(posedge ref_clk) begin
        if (!resetn) begin
            starts <= 0;
        end else if (adc_start === 1'b1) begin
            starts <= starts + 1;
        end
    end
    // Expected flags, signed for temperature, unsigned for supply
    function [7:0] tflags(input [9:0] t, input [9:0] e);
        begin
            tflags = 8'h00;
            tflags[0] = $signed(t[9:2]) > $signed(int_hi_lim);
            tflags[1] = $signed(t[9:2]) <= $signed(int_lo_lim);
            tflags[2] = $signed(e[9:2]) > $signed(ext_hi_lim);
            tflags[3] = $signed(e[9:2]) <= $signed(ext_lo_lim);
            tflags = tflags & ~{4'h0, limit_mask[3:0]};
        end
    endfunction
    function [7:0] vflags(input [9:0] v);
        begin
            vflags = 8'h00;
            vflags[0] = v[9:2] > vdd_hi_lim && !limit_mask[4];
            vflags[1] = v[9:2] <= vdd_lo_lim && !limit_mask[5];
        end
    endfunction
    task check(input string what, input [9:0] exp, input [9:0] seen);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("BAD %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // Register access, entered just after a rising edge
    task wr(input [7:0] a, input [7:0] d);
        begin
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge ref_clk);
            reg_wr <= 1'b0;
            @(posedge ref_clk);
        end
    endtask
    task rd(input [7:0] a);
        begin
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge ref_clk);
            reg_rd <= 1'b0;
            @(posedge ref_clk);
            got = reg_rdata;
        end
    endtask
    // Bounded wait for the next conversion start
    task next_start;
        begin
            n = 0;
            @(posedge ref_clk);
            while (adc_start !== 1'b1 && n < 300) begin
                n = n + 1;
                @(posedge ref_clk);
            end
            if (n >= 300) check("start_wait", 1, 0);
            ch = adc_chan;
        end
    endtask
    task give_verdict;
        begin
            if (miscompares == 0 && n_tests > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    // Main sequence
    initial begin
        {ref_clk, resetn, xfer_active, reg_wr, reg_rd, int_active_high} = 0;
        {reg_addr, reg_wdata, limit_mask, int_hi_lim, int_lo_lim} = 0;
        {ext_hi_lim, ext_lo_lim, vdd_hi_lim, vdd_lo_lim} = 0;
        {vv, tv, ev} = 0;
        {miscompares, n_tests} = 0;
        seed = 68;
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (20) @(posedge ref_clk);
        check("starts_off", 0, starts);
        check("amp_off", 0, ref_amp_on);
        rd(8'h18);
        check("cfg1", 0, got);
        rd(8'h19);
        check("cfg2", 0, got);
        rd(8'h55);
        check("unmapped", 0, got);
        // Round robin, averaging off; first trial puts limits on the edge
        wr(8'h19, 8'h20);
        for (k = 0; k < 4; k = k + 1) begin
            wr(8'h18, 8'h00);
            rd(8'h00);
            rd(8'h10);
            vv = 10'($random(seed));
            tv = 10'($random(seed));
            ev = 10'($random(seed));
            int_hi_lim <= (k == 0) ? tv[9:2] : 8'($random(seed));
            int_lo_lim <= (k == 0) ? tv[9:2] : 8'($random(seed));
            ext_hi_lim <= (k == 0) ? ev[9:2] : 8'($random(seed));
            ext_lo_lim <= (k == 0) ? ev[9:2] : 8'($random(seed));
            vdd_hi_lim <= (k == 0) ? vv[9:2] : 8'($random(seed));
            vdd_lo_lim <= (k == 0) ? vv[9:2] : 8'($random(seed));
            limit_mask <= (k == 0) ? 6'h00 : ev[5:0] ^ tv[9:4];
            int_active_high <= k[0];
            wr(8'h18, 8'h01);
            for (i = 0; i < 4; i = i + 1) begin
                next_start;
                check("rr_chan", i % 3, ch);
            end
            wr(8'h18, 8'h00);
            repeat (3) @(posedge ref_clk);
            fl0 = tflags(tv, ev);
            fl1 = vflags(vv);
            check("int_out", int_active_high ^ !(fl0 | fl1), int_out);
            rd(8'h03);
            check("low_a", {4'h0, tv[1:0], vv[1:0]}, got);
            rd(8'h04);
            check("low_b", {6'h00, ev[1:0]}, got);
            rd(8'h06);
            check("vdd_msb", vv[9:2], got);
            rd(8'h07);
            check("int_msb", tv[9:2], got);
            rd(8'h08);
            check("ext_msb", ev[9:2], got);
            rd(8'h00);
            check("tflags", fl0, got);
            rd(8'h10);
            check("vflags", fl1, got);
        end
        // Averaged round with a transfer in mid conversion
        // Fresh code so a missing commit cannot read back the old one
        tv = 10'($random(seed));
        wr(8'h19, 8'h00);
        wr(8'h18, 8'h01);
        cnt = 0;
        ch = 2'h0;
        for (i = 0; i < 40 && ch !== 2'h2; i = i + 1) begin
            next_start;
            if (ch === 2'h1) cnt = cnt + 1;
        end
        check("avg_runs", 16, cnt);
        repeat (20) @(posedge ref_clk);
        xfer_active <= 1'b1;
        repeat (10) @(posedge ref_clk);
        check("adc_reset", 1, adc_reset);
        xfer_active <= 1'b0;
        next_start;
        check("resume", 2, ch);
        wr(8'h18, 8'h00);
        rd(8'h07);
        check("int_avg", tv[9:2], got);
        // Low read freezes the int upper byte until an upper read
        fl0 = got;
        tv = ~tv;
        rd(8'h03);
        wr(8'h19, 8'h31);
        wr(8'h18, 8'h01);
        repeat (3) next_start;
        wr(8'h18, 8'h00);
        rd(8'h03);
        check("low_live", {4'h0, tv[1:0], vv[1:0]}, got);
        rd(8'h07);
        check("int_locked", fl0, got);
        wr(8'h18, 8'h01);
        repeat (3) next_start;
        wr(8'h18, 8'h00);
        rd(8'h07);
        check("int_freed", tv[9:2], got);
        // Single channel for every select code
        for (k = 0; k < 4; k = k + 1) begin
            wr(8'h18, 8'h00);
            wr(8'h19, {6'h0C, k[1:0]});
            rd(8'h19);
            check("cfg2", {6'h0C, k[1:0]}, got);
            wr(8'h18, 8'h01);
            cnt = starts;
            for (i = 0; i < 3 && k < 3; i = i + 1) begin
                next_start;
                check("single", k[1:0], ch);
            end
            repeat (30) @(posedge ref_clk);
            if (k == 3) check("rsv_idle", cnt, starts);
        end
        wr(8'h18, 8'h00);
        give_verdict;
    end
    // Cut a hang short
    initial begin
        #2000000;
        miscompares = miscompares + 1;
        give_verdict;
    end
endmodule
bind mms_sequencer mms_props u_props (.ref_clk(ref_clk), .resetn(resetn),
    .xfer_active(xfer_active), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .adc_start(adc_start), .adc_chan(adc_chan), .adc_reset(adc_reset),
    .adc_ref_int(adc_ref_int), .ref_amp_on(ref_amp_on));
